/* rws_pkg.sv */
// Purpose: Shared constants and types for the reset and watchdog sequencer
// Assumes: 100 MHz core clock
// Notes: Times are kept in microseconds, cycle counts derive from them
//
// Functional notes
// - Two reset sources restore register defaults
// - Either reset clears USB device addresses
// - Either reset leaves interrupts disabled
// - Either reset zeroes both stack pointers
// - Cause flags: bit 4 supply-up, bit 6 watchdog
// - Execution restarts at program address zero
// - Reset entry pushes nothing onto stack
// - Supply-up reset holds core in semi-suspend
// - Release needs good supply, stable oscillator
// - 1 ms uninterruptible, then 95 ms hold-off
// - Upstream bus reset aborts hold-off immediately
// - Early bus reset leaves its interrupt pending
// - Supply drop re-asserts reset, repeats sequence
// - Any write to 0x26 clears watchdog
// - Watchdog rolls over after 8 ms unrestarted
// - Watchdog reset loads status 010X0001
// - Watchdog reset held 2 ms, then run
// - Watchdog reset disables USB transmitter

package rws_pkg;

   // Clock rate and documented times
   localparam int CLK_MHZ = 100;
   localparam int T_NOINT_US = 1000;
   localparam int T_HOLDOFF_US = 95000;
   localparam int T_WDR_HOLD_US = 2000;
   localparam int T_WDOG_US = 8000;

   // Cycle counts, exact at 100 MHz
   localparam int NOINT_CYC = T_NOINT_US * CLK_MHZ;
   localparam int HOLDOFF_CYC = T_HOLDOFF_US * CLK_MHZ;
   localparam int WDR_HOLD_CYC = T_WDR_HOLD_US * CLK_MHZ;
   localparam int WDOG_CYC = T_WDOG_US * CLK_MHZ;

   // Counter width, covers the longest span
   localparam int CNT_W = 24;

   // I/O register map
   localparam logic [7:0] ADDR_INT_EN = 8'h20;
   localparam logic [7:0] ADDR_WDOG_RESTART = 8'h26;
   localparam logic [7:0] ADDR_PSC = 8'hff;

   // Field positions
   localparam int BIT_BUSRST_IE = 0;
   localparam int BIT_RUN = 0;
   localparam int BIT_POR = 4;
   localparam int BIT_WDR = 6;

   // Reset values
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] PSC_POR_VAL = 8'h11;
   localparam logic [7:0] PSC_WDR_VAL = 8'h41;
   localparam logic [7:0] PSC_WDR_KEEP = 8'h10;
   localparam logic [13:0] RESET_PC = 14'h0000;
   localparam logic [7:0] STACK_RST = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // Synchroniser lanes: supply, oscillator, bus reset
   localparam int SYNC_W = 3;
   localparam int LANE_SUPPLY = 0;
   localparam int LANE_OSC = 1;
   localparam int LANE_BUSRST = 2;

   // Sequencer states, Gray along the start-up path
   typedef enum logic [2:0] {
      RWS_POR_HOLD = 3'h0,
      RWS_NOINT = 3'h1,
      RWS_HOLDOFF = 3'h3,
      RWS_RUN = 3'h2,
      RWS_WDOG_HOLD = 3'h6
   } rws_seq_t;

   // Top-level state
   typedef struct packed {
      rws_seq_t seq;
      logic [CNT_W-1:0] cnt;
      logic bus_d;
      logic [7:0] int_en;
      logic [7:0] psc;
      logic gie;
      logic busrst_pend;
      logic [7:0] rdata;
      logic sys_rst_n;
      logic cpu_run;
      logic start;
      logic usb_tx_en;
      logic usb_addr_clr;
      logic irq;
      logic semi_susp;
      logic [13:0] fetch_addr;
      logic [7:0] stack_init;
      logic wdog_restart;
   } rws_state_t;

   // Watchdog state
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic roll;
   } rws_wdog_t;

   // Synchroniser state
   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } rws_sync_t;

endpackage : rws_pkg

/* rws_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps

module rws_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [rws_pkg::SYNC_W-1:0] d_i,
   output logic [rws_pkg::SYNC_W-1:0] q_o
);

   rws_pkg::rws_sync_t r; // Both stages
   rws_pkg::rws_sync_t n; // Next stages

   // Per-lane two-flop chain
   genvar g;
   generate
      for (g = 0; g < rws_pkg::SYNC_W; g = g + 1) begin : g_lane
         always_comb begin
            n.s1[g] = d_i[g];
            n.s2[g] = r.s1[g];
         end
      end
   endgenerate

   // Register, reset low so supply reads as absent
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign q_o = r.s2;

endmodule : rws_sync

/* rws_wdog.sv */
// Purpose: Watchdog counter with restart and rollover
// Assumes: Restart is a one-cycle pulse
// Notes: Counter held clear while the core is stopped
`timescale 1ns/10ps

module rws_wdog #(
   parameter int WDOG_CYC = rws_pkg::WDOG_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic restart_i,
   output logic roll_o
);

   rws_pkg::rws_wdog_t r; // Counter and rollover flag
   rws_pkg::rws_wdog_t n; // Next value

   // Count while running, roll over at the limit
   always_comb begin
      n = r;
      n.roll = 1'b0;
      if (!run_i) begin
         n.cnt = '0;
      end else if (restart_i) begin
         n.cnt = '0;
      end else if (r.cnt == rws_pkg::CNT_W'(WDOG_CYC - 1)) begin
         n.cnt = '0;
         n.roll = 1'b1;
      end else begin
         n.cnt = r.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign roll_o = r.roll;

endmodule : rws_wdog

/* rws_top.sv */
// Purpose: Supply-up and watchdog reset sequencer with cause flags
// Assumes: Single 100 MHz clock, pins synchronised here
// Notes: RST_N_I is treated exactly like a supply-up reset
`timescale 1ns/10ps

module rws_top #(
   parameter int NOINT_CYC = rws_pkg::NOINT_CYC,
   parameter int HOLDOFF_CYC = rws_pkg::HOLDOFF_CYC,
   parameter int WDR_HOLD_CYC = rws_pkg::WDR_HOLD_CYC,
   parameter int WDOG_CYC = rws_pkg::WDOG_CYC
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire logic SUPPLY_OK_I,
   input wire logic OSC_STABLE_I,
   input wire logic USB_BUS_RESET_I,
   input wire logic [7:0] IO_ADDR_I,
   input wire logic IO_WR_I,
   input wire logic IO_RD_I,
   input wire logic [7:0] IO_WDATA_I,
   input wire logic INT_UNMASK_I,
   input wire logic INT_MASK_I,
   input wire logic BUS_RST_ACK_I,
   output logic [7:0] IO_RDATA_O,
   output logic SYS_RST_N_O,
   output logic CPU_RUN_O,
   output logic EXEC_START_O,
   output logic [13:0] FETCH_ADDR_O,
   output logic [7:0] STACK_INIT_O,
   output logic SEMI_SUSPEND_O,
   output logic USB_TX_EN_O,
   output logic USB_ADDR_CLR_O,
   output logic [7:0] INT_ENABLE_O,
   output logic GLOBAL_IE_O,
   output logic BUS_RST_IRQ_O
);

   rws_pkg::rws_state_t r; // Registered state
   rws_pkg::rws_state_t n; // Next state

   logic [rws_pkg::SYNC_W-1:0] pin_raw; // Asynchronous pins
   logic [rws_pkg::SYNC_W-1:0] pin_q; // Synchronised pins
   logic wdog_roll; // Watchdog rollover pulse
   logic supply_ok; // Supply above threshold
   logic osc_ok; // Oscillator stable
   logic bus_lvl; // Upstream bus reset level
   logic bus_edge; // Start of a bus reset
   logic por_cond; // Supply-up reset asserted
   logic io_wr_ok; // Write accepted
   logic in_reset; // Next state is a reset hold

   // Gather pins for the synchroniser
   always_comb begin
      pin_raw = '0;
      pin_raw[rws_pkg::LANE_SUPPLY] = SUPPLY_OK_I;
      pin_raw[rws_pkg::LANE_OSC] = OSC_STABLE_I;
      pin_raw[rws_pkg::LANE_BUSRST] = USB_BUS_RESET_I;
   end

   // Pin synchroniser, two flops per lane
   rws_sync u_sync (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .d_i(pin_raw),
      .q_o(pin_q)
   );

   // Watchdog, only counts while the core executes
   rws_wdog #(
      .WDOG_CYC(WDOG_CYC)
   ) u_wdog (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .run_i(r.cpu_run),
      .restart_i(r.wdog_restart),
      .roll_o(wdog_roll)
   );

   // Decode of synchronised levels
   always_comb begin
      supply_ok = pin_q[rws_pkg::LANE_SUPPLY];
      osc_ok = pin_q[rws_pkg::LANE_OSC];
      bus_lvl = pin_q[rws_pkg::LANE_BUSRST];
      // Edge taken from second stage and its delayed copy
      bus_edge = bus_lvl & ~r.bus_d;
      // Reset stays asserted until both are good
      por_cond = ~supply_ok | ~osc_ok;
      // Firmware writes only count while it runs
      io_wr_ok = IO_WR_I & r.cpu_run;
   end

   // Next-state logic
   always_comb begin
      n = r;
      n.start = 1'b0;
      n.wdog_restart = 1'b0;
      n.bus_d = bus_lvl;

      // Register writes
      if (io_wr_ok) begin
         case (IO_ADDR_I)
            rws_pkg::ADDR_INT_EN: begin
               n.int_en = IO_WDATA_I;
            end
            rws_pkg::ADDR_WDOG_RESTART: begin
               // Data value is ignored
               n.wdog_restart = 1'b1;
            end
            rws_pkg::ADDR_PSC: begin
               n.psc = IO_WDATA_I;
            end
            default: begin
               // Unmapped, no effect
            end
         endcase
      end

      // Global mask, unmask instruction wins a tie
      if (INT_UNMASK_I & r.cpu_run) begin
         n.gie = 1'b1;
      end else if (INT_MASK_I) begin
         n.gie = 1'b0;
      end

      // Pending bus reset, a new event beats the clear
      if (BUS_RST_ACK_I) begin
         n.busrst_pend = 1'b0;
      end
      if (bus_edge && (r.seq == rws_pkg::RWS_HOLDOFF || r.seq == rws_pkg::RWS_RUN)) begin
         n.busrst_pend = 1'b1;
      end

      // Sequencer
      case (r.seq)
         rws_pkg::RWS_POR_HOLD: begin
            // Core stopped, other blocks alive
            n.cnt = '0;
            if (!por_cond) begin
               n.seq = rws_pkg::RWS_NOINT;
            end
         end
         rws_pkg::RWS_NOINT: begin
            // Bus reset is ignored in this window
            if (r.cnt == rws_pkg::CNT_W'(NOINT_CYC - 1)) begin
               n.cnt = '0;
               n.seq = rws_pkg::RWS_HOLDOFF;
            end else begin
               n.cnt = r.cnt + 1'b1;
            end
         end
         rws_pkg::RWS_HOLDOFF: begin
            if (bus_edge) begin
               // Early exit straight into execution
               n.cnt = '0;
               n.seq = rws_pkg::RWS_RUN;
               n.start = 1'b1;
            end else if (r.cnt == rws_pkg::CNT_W'(HOLDOFF_CYC - 1)) begin
               n.cnt = '0;
               n.seq = rws_pkg::RWS_RUN;
               n.start = 1'b1;
            end else begin
               n.cnt = r.cnt + 1'b1;
            end
         end
         rws_pkg::RWS_RUN: begin
            n.cnt = '0;
            if (wdog_roll) begin
               n.seq = rws_pkg::RWS_WDOG_HOLD;
               // Cause pattern, supply-up flag kept
               n.psc = rws_pkg::PSC_WDR_VAL | (r.psc & rws_pkg::PSC_WDR_KEEP);
            end
         end
         rws_pkg::RWS_WDOG_HOLD: begin
            if (r.cnt == rws_pkg::CNT_W'(WDR_HOLD_CYC - 1)) begin
               n.cnt = '0;
               n.seq = rws_pkg::RWS_RUN;
               n.start = 1'b1;
            end else begin
               n.cnt = r.cnt + 1'b1;
            end
         end
         default: begin
            // Illegal code recovers through supply-up path
            n.cnt = '0;
            n.seq = rws_pkg::RWS_POR_HOLD;
         end
      endcase

      // Supply loss overrides everything, from any state
      if (por_cond) begin
         n.seq = rws_pkg::RWS_POR_HOLD;
         n.cnt = '0;
         n.start = 1'b0;
         n.psc = rws_pkg::PSC_POR_VAL;
      end

      in_reset = (n.seq == rws_pkg::RWS_POR_HOLD) || (n.seq == rws_pkg::RWS_WDOG_HOLD);

      // Defaults forced for the length of either reset
      if (in_reset) begin
         n.int_en = rws_pkg::INT_EN_RST;
         n.gie = 1'b0;
         n.busrst_pend = 1'b0;
         n.wdog_restart = 1'b0;
      end

      // Core held off until a start; globally masked while stopped
      if (n.seq != rws_pkg::RWS_RUN) begin
         n.gie = 1'b0;
      end

      // Status outputs
      n.sys_rst_n = ~in_reset;
      n.cpu_run = (n.seq == rws_pkg::RWS_RUN);
      n.semi_susp = (n.seq == rws_pkg::RWS_POR_HOLD) || (n.seq == rws_pkg::RWS_NOINT) ||
                    (n.seq == rws_pkg::RWS_HOLDOFF);
      // Addresses cleared, so nothing may be transmitted
      n.usb_addr_clr = in_reset;
      n.usb_tx_en = ~in_reset;

      // Start vector and stacks are loaded, never pushed
      if (n.seq != rws_pkg::RWS_RUN) begin
         n.fetch_addr = rws_pkg::RESET_PC;
         n.stack_init = rws_pkg::STACK_RST;
      end
      // Start pulse is a plain load; nothing is pushed on a stack

      // Interrupt request, serviced only once both enables are set
      n.irq = n.busrst_pend & n.int_en[rws_pkg::BIT_BUSRST_IE] & n.gie & n.cpu_run;

      // Registered read port, one cycle latency
      n.rdata = rws_pkg::RDATA_IDLE;
      if (IO_RD_I) begin
         case (IO_ADDR_I)
            rws_pkg::ADDR_INT_EN: begin
               n.rdata = r.int_en;
            end
            rws_pkg::ADDR_PSC: begin
               // Cause bits readable here
               n.rdata = r.psc;
            end
            default: begin
               // Restart register is write only, unmapped reads zero
               n.rdata = rws_pkg::RDATA_IDLE;
            end
         endcase
      end
   end

   // State register; reset gives the supply-up defaults
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         r <= '0;
         r.psc <= rws_pkg::PSC_POR_VAL;
         r.usb_addr_clr <= 1'b1;
         r.semi_susp <= 1'b1;
      end else if (CE_I) begin
         r <= n;
      end
   end

   // Outputs straight from flops
   assign IO_RDATA_O = r.rdata;
   assign SYS_RST_N_O = r.sys_rst_n;
   assign CPU_RUN_O = r.cpu_run;
   assign EXEC_START_O = r.start;
   assign FETCH_ADDR_O = r.fetch_addr;
   assign STACK_INIT_O = r.stack_init;
   assign SEMI_SUSPEND_O = r.semi_susp;
   assign USB_TX_EN_O = r.usb_tx_en;
   assign USB_ADDR_CLR_O = r.usb_addr_clr;
   assign INT_ENABLE_O = r.int_en;
   assign GLOBAL_IE_O = r.gie;
   assign BUS_RST_IRQ_O = r.irq;

endmodule : rws_top

/* rws_chk.sv */
// Purpose: Port-level assertions for the reset and watchdog sequencer
// Assumes: One clock, RST_N_I synchronous and active low
// Notes: Span checks allow a cycle of slack on the hold length and two on the timeout, for the output registers
`timescale 1ns/10ps

module rws_chk #(
   parameter int WDR_HOLD_CYC = 10,
   parameter int WDOG_CYC = 50
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire logic SUPPLY_OK_I,
   input wire logic [7:0] IO_ADDR_I,
   input wire logic IO_WR_I,
   input wire logic IO_RD_I,
   input wire logic [7:0] IO_WDATA_I,
   input wire logic [7:0] IO_RDATA_O,
   input wire logic SYS_RST_N_O,
   input wire logic CPU_RUN_O,
   input wire logic EXEC_START_O,
   input wire logic [13:0] FETCH_ADDR_O,
   input wire logic [7:0] STACK_INIT_O,
   input wire logic SEMI_SUSPEND_O,
   input wire logic USB_TX_EN_O,
   input wire logic USB_ADDR_CLR_O,
   input wire logic [7:0] INT_ENABLE_O,
   input wire logic GLOBAL_IE_O,
   input wire logic BUS_RST_IRQ_O
);
   default clocking dflt_cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   int hold_n; // Cycles spent in watchdog hold
   int run_n; // Cycles since run start or last restart

   // Span counters; a restart write zeroes the run count, a stall freezes both
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         hold_n <= 0;
         run_n <= 0;
      end else if (CE_I) begin
         hold_n <= (!SYS_RST_N_O && !SEMI_SUSPEND_O) ? hold_n + 1 : 0;
         run_n <= (!CPU_RUN_O || (IO_WR_I && IO_ADDR_I == 8'h26)) ? 0 : run_n + 1;
      end
   end

   start_fetch_a: assert property (EXEC_START_O |-> CPU_RUN_O && FETCH_ADDR_O == 14'h0000
      && STACK_INIT_O == 8'h00) else $error("start not at zero");
   reset_clear_a: assert property (!SYS_RST_N_O |-> USB_ADDR_CLR_O && !USB_TX_EN_O
      && INT_ENABLE_O == 8'h00 && !GLOBAL_IE_O) else $error("reset left state");
   semi_halt_a: assert property (SEMI_SUSPEND_O |-> !CPU_RUN_O && !EXEC_START_O)
      else $error("core ran in semi-suspend");
   supply_drop_a: assert property ((!SUPPLY_OK_I && CE_I) [*5] |=> SEMI_SUSPEND_O && !CPU_RUN_O)
      else $error("supply drop not obeyed");
   int_en_wr_a: assert property (CE_I && IO_WR_I && CPU_RUN_O && IO_ADDR_I == 8'h20
      |=> !SYS_RST_N_O || INT_ENABLE_O == $past(IO_WDATA_I)) else $error("enable write lost");
   restart_ro_a: assert property (CE_I && IO_RD_I && IO_ADDR_I == 8'h26 |=> IO_RDATA_O == 8'h00)
      else $error("restart register readable");
   wdr_hold_a: assert property ($rose(SYS_RST_N_O) && !SEMI_SUSPEND_O && hold_n != 0
      |-> hold_n >= WDR_HOLD_CYC - 1 && hold_n <= WDR_HOLD_CYC + 1) else $error("hold length");
   wdog_span_a: assert property ($fell(SYS_RST_N_O) && !SEMI_SUSPEND_O
      |-> run_n >= WDOG_CYC - 2 && run_n <= WDOG_CYC + 2) else $error("timeout length");
   irq_gate_a: assert property (BUS_RST_IRQ_O |-> GLOBAL_IE_O && INT_ENABLE_O[0] && CPU_RUN_O)
      else $error("irq while masked");

   cover property ($rose(CPU_RUN_O));
   cover property (BUS_RST_IRQ_O);
   cover property ($fell(SYS_RST_N_O) && !SEMI_SUSPEND_O);
endmodule : rws_chk

bind rws_top rws_chk #(.WDR_HOLD_CYC(WDR_HOLD_CYC), .WDOG_CYC(WDOG_CYC)) rws_chk_i (.*);

/* rws_host_model.sv */
// Purpose: Upstream host that raises a USB bus reset on command
// Assumes: Bus reset is a level held for a few clocks
// Notes: Real bus resets are far longer; shortened to keep runs brief
`timescale 1ns/10ps

module rws_host_model #(
   parameter int HOLD_CYC = 4 // Bus reset length in clocks
) (
   input wire logic clk_i,
   input wire logic fire_i,
   output logic bus_rst_o
);
   int left_r = 0; // Clocks of bus reset still to drive

   // Load on command, count down, drive while nonzero
   always_ff @(posedge clk_i) begin
      if (fire_i) begin
         left_r <= HOLD_CYC;
      end else if (left_r != 0) begin
         left_r <= left_r - 1;
      end
   end
   assign bus_rst_o = (left_r != 0);
endmodule : rws_host_model

/* rws_tb_top.sv */
// Purpose: Self-checking bench for the reset and watchdog sequencer
// Assumes: Shortened counts: 20, 40, 10 and 50 cycles
// Notes: Steps share the bus tasks; the watchdog is kicked well in time
`timescale 1ns/10ps

module rws_tb_top;
   localparam int NOINT = 20;
   localparam int HOLDOFF = 40;
   localparam int WDR_HOLD = 10;
   localparam int WDOG = 50;
   logic clk, rst_n, supply_ok, osc_ok, fire, bus_rst; // Stimulus
   logic io_wr, io_rd, unmask, mask, ack, ce; // Strobes and clock enable
   logic [7:0] io_addr, io_wdata, rdata, stack, int_en; // Bus data
   logic sys_rst_n, cpu_run, exec_start, semi, tx_en, addr_clr, gie, irq; // Status
   logic [13:0] fetch; // Fetch address
   int failures = 0; // Mismatches
   int n_checks = 0; // Comparisons
   int n; // Cycle counts

   rws_top #(.NOINT_CYC(NOINT), .HOLDOFF_CYC(HOLDOFF), .WDR_HOLD_CYC(WDR_HOLD),
      .WDOG_CYC(WDOG)) rws_top_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .SUPPLY_OK_I(supply_ok), .OSC_STABLE_I(osc_ok), .USB_BUS_RESET_I(bus_rst),
      .IO_ADDR_I(io_addr), .IO_WR_I(io_wr), .IO_RD_I(io_rd), .IO_WDATA_I(io_wdata),
      .INT_UNMASK_I(unmask), .INT_MASK_I(mask), .BUS_RST_ACK_I(ack), .IO_RDATA_O(rdata),
      .SYS_RST_N_O(sys_rst_n), .CPU_RUN_O(cpu_run), .EXEC_START_O(exec_start),
      .FETCH_ADDR_O(fetch), .STACK_INIT_O(stack), .SEMI_SUSPEND_O(semi),
      .USB_TX_EN_O(tx_en), .USB_ADDR_CLR_O(addr_clr), .INT_ENABLE_O(int_en),
      .GLOBAL_IE_O(gie), .BUS_RST_IRQ_O(irq));
   rws_host_model rws_host_model_i (.clk_i(clk), .fire_i(fire), .bus_rst_o(bus_rst));

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) {io_addr, io_wdata, io_wr} <= {a, d, 1'b1};
      @(posedge clk) io_wr <= 1'b0;
   endtask : wr

   // One read cycle, data settles after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) {io_addr, io_rd} <= {a, 1'b1};
      @(posedge clk) io_rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd

   // Bounded wait for the start pulse
   task automatic wait_start(input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (exec_start !== 1'b1 && k < lim);
      chk(exec_start, 1'b1);
   endtask : wait_start

   // Bounded count of cycles until a watchdog reset begins
   task automatic wait_roll(output int k);
      k = 0;
      while (sys_rst_n === 1'b1 && k < WDOG + 20) begin
         @(posedge clk);
         #1 k++;
      end
   endtask : wait_roll

   // Firmware view of the cause: supply-up flag masks the watchdog flag
   function automatic logic [1:0] cause_of(input logic [7:0] psc);
      return psc[rws_pkg::BIT_POR] ? 2'b01 : {psc[rws_pkg::BIT_WDR], 1'b0};
   endfunction : cause_of

   // Counts, verdict, end of run
   task automatic give_verdict;
      $display("Checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, far beyond the expected few hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      give_verdict();
   end

   // Main sequence
   initial begin
      {rst_n, fire, io_wr, io_rd, unmask, mask, ack} = '0;
      {ce, supply_ok, osc_ok, io_addr, io_wdata} = {3'b111, 16'h0000};
      repeat (16) @(posedge clk);
      #1 chk({sys_rst_n, semi, tx_en, addr_clr, rdata}, 12'h500);
      @(posedge clk) rst_n <= 1'b1;
      wait_start(NOINT + HOLDOFF + 20, n);
      chk(n >= NOINT + HOLDOFF, 1'b1);
      chk({fetch, stack, semi}, 23'h0);
      rd(8'hff, 8'h11);
      rd(8'h20, 8'h00);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h5a);
      rd(8'h26, 8'h00);
      rd(8'h3c, 8'h00);
      wr(8'hff, 8'h01);
      // Kicks keep the core alive, then stop and time the rollover
      repeat (6) begin
         repeat (20) @(posedge clk);
         wr(8'h26, 8'ha5);
      end
      #1 chk({cpu_run, sys_rst_n}, 2'b11);
      wait_roll(n);
      chk(n >= WDOG - 2 && n <= WDOG + 5, 1'b1);
      chk({int_en, gie, tx_en, addr_clr}, 11'h1);
      wait_start(WDR_HOLD + 10, n);
      chk(n >= WDR_HOLD - 1, 1'b1);
      rd(8'hff, 8'h41);
      chk(cause_of(rdata), 2'b10);
      // Supply drop forces the full sequence again
      @(posedge clk) supply_ok <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk({semi, cpu_run}, 2'b10);
      rd(8'hff, 8'h11);
      // Supply back but oscillator not yet stable: still held
      @(posedge clk) {supply_ok, osc_ok} <= 2'b10;
      repeat (6) @(posedge clk);
      #1 chk({semi, sys_rst_n}, 2'b10);
      @(posedge clk) osc_ok <= 1'b1;
      repeat (8) @(posedge clk);
      // Bus reset in the first window is ignored, later it cuts in
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      repeat (22) @(posedge clk);
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      wait_start(6, n);
      chk(irq, 1'b0);
      wr(8'h20, 8'h01);
      @(posedge clk) unmask <= 1'b1;
      @(posedge clk) unmask <= 1'b0;
      @(posedge clk);
      #1 chk({irq, gie}, 2'b11);
      @(posedge clk) ack <= 1'b1;
      @(posedge clk) ack <= 1'b0;
      @(posedge clk);
      #1 chk(irq, 1'b0);
      @(posedge clk) mask <= 1'b1;
      @(posedge clk) mask <= 1'b0;
      @(posedge clk);
      #1 chk(gie, 1'b0);
      // Kick, then a clock-enable stall must not advance the watchdog
      wr(8'h26, 8'h00);
      @(posedge clk) ce <= 1'b0;
      repeat (30) @(posedge clk);
      @(posedge clk) ce <= 1'b1;
      #1 wait_roll(n);
      chk(n >= WDOG - 2 && n <= WDOG + 5, 1'b1);
      wait_start(WDR_HOLD + 10, n);
      chk(n >= WDR_HOLD - 1, 1'b1);
      // Supply-up flag was not cleared after the supply drop, so it survives the watchdog reset
      rd(8'hff, 8'h51);
      chk(cause_of(rdata), 2'b01);
      give_verdict();
   end
endmodule : rws_tb_top
